//--- core/bridge_steer.sv
// full-bridge pwm steering with auto-shutdown and an axi4-lite slave
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns

// What this block does
// (RULE1) full bridge drives all four outputs
// (RULE2) forward: a active, d modulated, b c inactive
// (RULE3) reverse: c active, b modulated, a d inactive
// (RULE4) direction change applies from next pwm cycle
// (RULE5) change: modulated off, a/c switch, resume next
// (RULE6) direction write accepted anywhere in cycle
// (RULE7) a/c switch one prescale interval early
// (RULE8) no dead band in full bridge
// (RULE9) firmware lowers duty before high-duty reversal
// (RULE10) polarity chosen separately per output pair
// (RULE11) firmware sets polarity before enabling drivers
// (RULE12) firmware waits one full cycle before drivers
// (RULE13) timer flag set when second period begins
// (RULE14) firmware sets pin directions to output
// (RULE15) shutdown from pin low, comparators, firmware
// (RULE16) three-bit field selects shutdown sources
// (RULE17) status reads one while shut down
// (RULE18) status stays set until firmware clears
// (RULE19) shutdown forces outputs without clock wait
// (RULE20) each pair takes its own shutdown state
// (RULE21) source select decode 000 to 111
// (RULE22) pair state: 00 low, 01 high, 1x hi-z
module bridge_steer
  import bridge_pkg::*;
(
  input  wire logic                         mclk,
  input  wire logic                         rst,
  input  wire logic [bridge_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [bridge_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [bridge_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [bridge_pkg::DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         event_pin,
  input  wire logic                         comparator_one,
  input  wire logic                         comparator_two,
  output logic                              out_a,
  output logic                              out_a_oe_n,
  output logic                              out_b,
  output logic                              out_b_oe_n,
  output logic                              out_c,
  output logic                              out_c_oe_n,
  output logic                              out_d,
  output logic                              out_d_oe_n
);
  import bridge_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        en;
    logic        dir_req;
    logic        dir_act;
    logic        chg;
    logic [1:0]  pol;
    logic [1:0]  pre;
    logic [3:0]  drv;
    logic [7:0]  period;
    logic [7:0]  duty;
    logic [2:0]  sd_src;
    logic [1:0]  sd_ac;
    logic [1:0]  sd_bd;
    logic        sd_stat;
    logic        tmr_flag;
    logic [3:0]  pre_cnt;
    logic [7:0]  tmr;
    logic [3:0]  lvl;
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } state_s;

  state_s      st_ff;
  state_s      nxt_st;

  logic        wr_go;
  logic        rd_go;
  logic        ev;
  logic        sd_act;
  logic        sd_on;
  logic [3:0]  pre_top;
  logic        tick;
  logic        pwm;
  logic [3:0]  pin_lvl;
  logic [3:0]  pin_oe_n;

  // ----------------------------------------------------------------
  // byte lane merge
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  stb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~st_ff.bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid & ~st_ff.rvalid;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rresp   = st_ff.rresp;
  assign s_axi_rdata   = st_ff.rdata;

  // ----------------------------------------------------------------
  // shutdown detection
  // ----------------------------------------------------------------
  assign ev = (st_ff.sd_src[0] & st_ff.sync2[1])      // RULE21
            | (st_ff.sd_src[1] & st_ff.sync2[2])      // RULE21
            | (st_ff.sd_src[2] & ~st_ff.sync2[0]);    // RULE15
  assign sd_act = st_ff.sd_stat | ev;                 // RULE19
  assign sd_on  = sd_act & st_ff.en;

  // ----------------------------------------------------------------
  // prescale divider
  // ----------------------------------------------------------------
  always_comb begin
    unique case (st_ff.pre)
      2'h0:    pre_top = PRE_TOP_1;
      2'h1:    pre_top = PRE_TOP_4;
      default: pre_top = PRE_TOP_16;
    endcase
  end

  // a shorter prescale picked mid-count rolls over at once
  assign tick = (st_ff.pre_cnt >= pre_top);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] w;
    w      = 32'h0;
    pwm    = 1'b0;
    nxt_st = st_ff;

    nxt_st.sync1 = {comparator_two, comparator_one, event_pin};
    nxt_st.sync2 = st_ff.sync1;

    // --------------------------------------------------------------
    // period timer and direction sequencing
    // --------------------------------------------------------------
    if (!st_ff.en) begin
      nxt_st.tmr     = 8'h00;
      nxt_st.pre_cnt = 4'h0;
      nxt_st.chg     = 1'b0;
      nxt_st.dir_act = st_ff.dir_req;
      nxt_st.lvl     = 4'h0;
    end else begin
      nxt_st.pre_cnt = tick ? 4'h0 : st_ff.pre_cnt + 4'h1;
      if (tick) begin
        if (st_ff.tmr == st_ff.period) begin
          nxt_st.tmr      = 8'h00;
          nxt_st.tmr_flag = 1'b1;                     // RULE13
          nxt_st.chg      = 1'b0;                     // RULE5
        end else begin
          nxt_st.tmr = st_ff.tmr + 8'h01;
        end
      end
      // switch a/c one prescale interval before period end
      // a request landing inside that last interval waits a period
      if (nxt_st.tmr == st_ff.period && nxt_st.pre_cnt == 4'h0 &&
          st_ff.dir_req != st_ff.dir_act) begin       // RULE4 RULE6
        nxt_st.dir_act = st_ff.dir_req;               // RULE7
        nxt_st.chg     = 1'b1;                        // RULE5
      end
      // modulation, no dead band applied
      pwm = (nxt_st.tmr < st_ff.duty) & ~nxt_st.chg;  // RULE8 RULE5
      if (!nxt_st.dir_act) begin
        nxt_st.lvl = {pwm, 1'b0, 1'b0, 1'b1};         // RULE2 RULE1
      end else begin
        nxt_st.lvl = {1'b0, 1'b1, pwm, 1'b0};         // RULE3 RULE1
      end
    end

    // --------------------------------------------------------------
    // write channel
    // --------------------------------------------------------------
    if (wr_go) begin
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = RESP_OKAY;
      unique case (s_axi_awaddr)
        ADDR_CTRL: begin
          w = merge({20'h0, st_ff.drv, 2'h0, st_ff.pre,
                     st_ff.pol, st_ff.dir_req,
                     st_ff.en},
                    s_axi_wdata, s_axi_wstrb);
          nxt_st.en      = w[CTRL_EN];
          nxt_st.dir_req = w[CTRL_DIR];               // RULE6
          nxt_st.pol     = w[CTRL_POL +: 2];
          nxt_st.pre     = w[CTRL_PRE +: 2];
          nxt_st.drv     = w[CTRL_DRV +: 4];
        end
        ADDR_PERIOD: begin
          w = merge({24'h0, st_ff.period}, s_axi_wdata, s_axi_wstrb);
          nxt_st.period = w[7:0];
        end
        ADDR_DUTY: begin
          w = merge({24'h0, st_ff.duty}, s_axi_wdata, s_axi_wstrb);
          nxt_st.duty = w[7:0];
        end
        ADDR_SHDN: begin
          w = merge({24'h0, st_ff.sd_stat, st_ff.sd_src, st_ff.sd_ac,
                     st_ff.sd_bd}, s_axi_wdata, s_axi_wstrb);
          nxt_st.sd_stat = w[SD_STATUS];              // RULE15 RULE18
          nxt_st.sd_src  = w[SD_SRC +: 3];            // RULE16
          nxt_st.sd_ac   = w[SD_AC +: 2];
          nxt_st.sd_bd   = w[SD_BD +: 2];
        end
        ADDR_STAT: begin
          if (s_axi_wstrb[0] && s_axi_wdata[ST_FLAG]) begin
            nxt_st.tmr_flag = 1'b0;
          end
        end
        default: nxt_st.bresp = RESP_SLVERR;
      endcase
    end else if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // --------------------------------------------------------------
    // hardware sets win over software clears
    // --------------------------------------------------------------
    if (ev) begin
      nxt_st.sd_stat = 1'b1;                          // RULE18
    end
    if (st_ff.en && tick && st_ff.tmr == st_ff.period) begin
      nxt_st.tmr_flag = 1'b1;                         // RULE13
    end

    // --------------------------------------------------------------
    // read channel
    // --------------------------------------------------------------
    if (rd_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = RESP_OKAY;
      nxt_st.rdata  = 32'h0;
      unique case (s_axi_araddr)
        ADDR_CTRL: begin
          nxt_st.rdata = {20'h0, st_ff.drv, 2'h0, st_ff.pre,
                          st_ff.pol, st_ff.dir_req,
                          st_ff.en};
        end
        ADDR_PERIOD: nxt_st.rdata = {24'h0, st_ff.period};
        ADDR_DUTY:   nxt_st.rdata = {24'h0, st_ff.duty};
        ADDR_SHDN: begin
          nxt_st.rdata = {24'h0, sd_act, st_ff.sd_src,
                          st_ff.sd_ac, st_ff.sd_bd};  // RULE17
        end
        ADDR_STAT: begin
          nxt_st.rdata = {28'h0, sd_act, st_ff.chg, st_ff.dir_act,
                          st_ff.tmr_flag};
        end
        default: nxt_st.rresp = RESP_SLVERR;
      endcase
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff        <= '0;
      st_ff.period <= PERIOD_RST;
      st_ff.duty   <= DUTY_RST;
      st_ff.sync1  <= 3'h1;
      st_ff.sync2  <= 3'h1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // output pins: polarity, shutdown override, drivers
  // ----------------------------------------------------------------
  // shutdown overrides the registered levels with no clock edge
  always_comb begin
    pin_lvl  = 4'h0;
    pin_oe_n = 4'hf;
    for (int i = 0; i < 4; i++) begin
      // pair a/c is even index, pair b/d is odd index
      if (sd_on) begin
        pin_lvl[i]  = (i % 2 == 0) ? st_ff.sd_ac[0]
                                   : st_ff.sd_bd[0];  // RULE20 RULE22
        pin_oe_n[i] = ~st_ff.drv[i] |
                      ((i % 2 == 0) ? st_ff.sd_ac[1]
                                    : st_ff.sd_bd[1]); // RULE22
      end else begin
        pin_lvl[i]  = st_ff.lvl[i] ^
                      ((i % 2 == 0) ? st_ff.pol[1]
                                    : st_ff.pol[0]);  // RULE10
        pin_oe_n[i] = ~(st_ff.en & st_ff.drv[i]);     // RULE1
      end
    end
  end

  // ----------------------------------------------------------------
  // pin fan-out
  // ----------------------------------------------------------------
  assign out_a      = pin_lvl[0];
  assign out_b      = pin_lvl[1];
  assign out_c      = pin_lvl[2];
  assign out_d      = pin_lvl[3];
  assign out_a_oe_n = pin_oe_n[0];
  assign out_b_oe_n = pin_oe_n[1];
  assign out_c_oe_n = pin_oe_n[2];
  assign out_d_oe_n = pin_oe_n[3];

endmodule

//--- pkg/bridge_pkg.sv
// constants for the full-bridge steering and shutdown block
package bridge_pkg;

  // ----------------------------------------------------------------
  // bus
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_PERIOD = 8'h04;
  localparam logic [7:0]  ADDR_DUTY   = 8'h08;
  localparam logic [7:0]  ADDR_SHDN   = 8'h0c;
  localparam logic [7:0]  ADDR_STAT   = 8'h10;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int          CTRL_EN     = 0;
  localparam int          CTRL_DIR    = 1;
  localparam int          CTRL_POL    = 2;
  localparam int          CTRL_PRE    = 4;
  localparam int          CTRL_DRV    = 8;

  // ----------------------------------------------------------------
  // shutdown control register fields
  // ----------------------------------------------------------------
  localparam int          SD_BD       = 0;
  localparam int          SD_AC       = 2;
  localparam int          SD_SRC      = 4;
  localparam int          SD_STATUS   = 7;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int          ST_FLAG     = 0;
  localparam int          ST_DIR      = 1;
  localparam int          ST_CHG      = 2;
  localparam int          ST_SD       = 3;

  // ----------------------------------------------------------------
  // prescale terminal counts (divide by 1, 4, 16)
  // ----------------------------------------------------------------
  localparam logic [3:0]  PRE_TOP_1   = 4'h0;
  localparam logic [3:0]  PRE_TOP_4   = 4'h3;
  localparam logic [3:0]  PRE_TOP_16  = 4'hf;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  PERIOD_RST  = 8'hff;
  localparam logic [7:0]  DUTY_RST    = 8'h00;

endpackage

//--- verification/bridge_load.sv
// gate drivers and switches of the external bridge
`timescale 1ns/1ns
module bridge_load (
  input wire logic mclk,
  input wire logic out_a,
  input wire logic out_a_oe_n,
  input wire logic out_b,
  input wire logic out_b_oe_n,
  input wire logic out_c,
  input wire logic out_c_oe_n,
  input wire logic out_d,
  input wire logic out_d_oe_n,
  input wire logic inv_ac,
  input wire logic inv_bd,
  output int       shoot_cnt
);
  logic pa, pb, pc, pd;
  // released pins are pulled to the switch-off level
  assign pa = out_a_oe_n ? inv_ac : out_a;
  assign pb = out_b_oe_n ? inv_bd : out_b;
  assign pc = out_c_oe_n ? inv_ac : out_c;
  assign pd = out_d_oe_n ? inv_bd : out_d;
  initial shoot_cnt = 0;
  // gate polarity follows the pair polarity; count shorted legs
  always @(posedge mclk) begin
    if (((pa ^ inv_ac) && (pb ^ inv_bd)) ||
        ((pc ^ inv_ac) && (pd ^ inv_bd))) begin
      shoot_cnt <= shoot_cnt + 1;
    end
  end
endmodule

//--- verification/bridge_steer_monitor.sv
// port assertions for the bridge steering block
`timescale 1ns/1ns
module bridge_steer_monitor
  import bridge_pkg::*;
(
  input wire logic                     mclk,
  input wire logic                     rst,
  input wire logic [bridge_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic [bridge_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [bridge_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire logic                     event_pin,
  input wire logic                     comparator_one,
  input wire logic                     out_a,
  input wire logic                     out_a_oe_n,
  input wire logic                     out_b,
  input wire logic                     out_b_oe_n,
  input wire logic                     out_c,
  input wire logic                     out_c_oe_n,
  input wire logic                     out_d,
  input wire logic                     out_d_oe_n
);
  // ----------------------------------------------------------------
  // shadow of control and shutdown settings
  // ----------------------------------------------------------------
  logic [11:0] ctrl_ff;
  logic [6:0]  shdn_ff;
  logic        wr_take;
  logic        plain;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid;
  assign plain = ctrl_ff[0] && ctrl_ff[3:2] == 2'h0 && shdn_ff[3:0] == 4'h0;
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_ff <= 12'h000;
      shdn_ff <= 7'h00;
    end else if (wr_take && s_axi_awaddr == ADDR_CTRL) begin
      ctrl_ff <= s_axi_wdata[11:0];
    end else if (wr_take && s_axi_awaddr == ADDR_SHDN) begin
      shdn_ff <= s_axi_wdata[6:0];
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wr_resp_a: assert property (wr_take && s_axi_wready |=> s_axi_bvalid)
    else $error("write response missing");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  bad_addr_a: assert property (wr_take && s_axi_awaddr > ADDR_STAT
    |=> s_axi_bresp == RESP_SLVERR) else $error("unmapped write okay");
  wr_gate_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while busy");
  drv_off_a: assert property (!ctrl_ff[0] ##1 !ctrl_ff[0] |-> out_a_oe_n
    && out_b_oe_n && out_c_oe_n && out_d_oe_n) else $error("idle pin driven");
  one_leg_a: assert property (plain [*2] |-> !(out_b && out_d)
    && !(out_a && out_c)) else $error("two legs active");
  ac_high_a: assert property ($rose(comparator_one) && shdn_ff[4] &&
    shdn_ff[3:2] == 2'h1 && ctrl_ff[0] && ctrl_ff[11:8] == 4'hf |->
    ##[1:3] out_a && out_c && !out_a_oe_n && !out_c_oe_n)
    else $error("a/c not forced high");
  bd_float_a: assert property ($fell(event_pin) && shdn_ff[6] &&
    shdn_ff[1] && ctrl_ff[0] |-> ##[1:3] out_b_oe_n && out_d_oe_n)
    else $error("b/d not released");
  cover property (wr_take && s_axi_awaddr == ADDR_SHDN);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (ctrl_ff[0] && out_b_oe_n && out_d_oe_n);
endmodule

bind bridge_steer bridge_steer_monitor u_bridge_steer_monitor (.mclk, .rst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .event_pin,
  .comparator_one, .out_a, .out_a_oe_n, .out_b, .out_b_oe_n, .out_c,
  .out_c_oe_n, .out_d, .out_d_oe_n);

//--- verification/tb.sv
// self-checking bench for the bridge steering block
`timescale 1ns/1ns
module tb;
  import bridge_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1, inv_ac = 1'b0, inv_bd = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, event_pin = 1'b1;
  logic        comparator_one = 1'b0, comparator_two = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, out_a, out_b, out_c, out_d;
  logic        out_a_oe_n, out_b_oe_n, out_c_oe_n, out_d_oe_n, x;
  logic [3:0]  oe_all;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          n_errors = 0, checks_done = 0, shoot_cnt, ka, kd, bad;
  always #20 mclk = ~mclk;
  assign oe_all = {out_a_oe_n, out_b_oe_n, out_c_oe_n, out_d_oe_n};
  bridge_steer u_bridge_steer (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .event_pin, .comparator_one, .comparator_two, .out_a, .out_a_oe_n, .out_b,
    .out_b_oe_n, .out_c, .out_c_oe_n, .out_d, .out_d_oe_n);
  bridge_load u_bridge_load (.mclk, .out_a, .out_a_oe_n, .out_b, .out_b_oe_n,
    .out_c, .out_c_oe_n, .out_d, .out_d_oe_n, .inv_ac, .inv_bd, .shoot_cnt);
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] e = RESP_OKAY);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge mclk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_bvalid);
    // ready raised late so the held response is exercised
    s_axi_bready <= 1'b1;
    @(posedge mclk);
    cmp("bresp", e, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er = RESP_OKAY);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    cmp($sformatf("rdata %h", a), e, s_axi_rdata);
    cmp("rresp", er, s_axi_rresp);
    s_axi_rready <= 1'b0;
  endtask
  // drivers off, polarity set, drivers on, then one period of levels
  task automatic run_chk(input logic [11:0] c, input logic [31:0] e);
    logic [31:0] n;
    n = 0;
    axi_wr(ADDR_CTRL, {24'h0, c[7:0]});
    inv_ac <= c[3];
    inv_bd <= c[2];
    axi_wr(ADDR_CTRL, {20'h0, c});
    repeat (20) @(posedge mclk);
    cmp("oe_n", 4'h0, oe_all);
    repeat (8) begin
      @(posedge mclk);
      n = n + {7'h0, out_a, 7'h0, out_b, 7'h0, out_c, 7'h0, out_d};
    end
    cmp("levels", e, n);
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(ADDR_PERIOD, 32'hff);
    rd_chk(ADDR_CTRL, 32'h0);
    rd_chk(8'h40, 32'h0, RESP_SLVERR);
    axi_wr(8'h40, 32'h1, RESP_SLVERR);
    cmp("oe_n", 4'hf, oe_all);
    axi_wr(ADDR_PERIOD, 32'h7);
    axi_wr(ADDR_DUTY, 32'h3);
    axi_wr(ADDR_CTRL, 32'h1);
    rd_chk(ADDR_STAT, 32'h0);
    repeat (20) @(posedge mclk);
    rd_chk(ADDR_STAT, 32'h1);
    run_chk(12'hf01, {8'd8, 8'd0, 8'd0, 8'd3});
    axi_wr(ADDR_DUTY, 32'h1);
    run_chk(12'hf03, {8'd0, 8'd1, 8'd8, 8'd0});
    axi_wr(ADDR_CTRL, 32'hf13);
    do @(posedge mclk); while (!out_b);
    axi_wr(ADDR_CTRL, 32'hf11);
    {ka, kd, bad} = 0;
    for (int k = 1; k < 80; k++) begin
      @(posedge mclk);
      if (out_a && ka == 0) ka = k;
      if (out_d && kd == 0) kd = k;
      if (ka != 0 && out_b) bad = 1;
    end
    cmp("swap", 1, ka > 20 && ka < 26);
    cmp("lead", 4, kd - ka);
    cmp("b_off", 0, bad);
    run_chk(12'hf09, {8'd0, 8'd0, 8'd8, 8'd1});
    run_chk(12'hf0d, {8'd0, 8'd8, 8'd8, 8'd7});
    run_chk(12'hf01, {8'd8, 8'd0, 8'd0, 8'd1});
    rd_chk(ADDR_CTRL, 32'hf01);
    for (int k = 0; k < 8; k++) begin
      for (int s = 0; s < 3; s++) begin
        axi_wr(ADDR_SHDN, k * 16 + 6);
        comparator_one <= (s == 0);
        comparator_two <= (s == 1);
        event_pin <= (s != 2);
        repeat (5) @(posedge mclk);
        x = k[s];
        cmp("out_c", x, out_c);
        cmp("bd_oe_n", {x, x}, {out_b_oe_n, out_d_oe_n});
        comparator_one <= 1'b0;
        comparator_two <= 1'b0;
        event_pin <= 1'b1;
        repeat (5) @(posedge mclk);
        rd_chk(ADDR_SHDN, k * 16 + 6 + x * 128);
        axi_wr(ADDR_SHDN, 32'h0);
      end
    end
    axi_wr(ADDR_SHDN, 32'h81);
    cmp("fw_levels", 4'h5, {out_a, out_b, out_c, out_d});
    axi_wr(ADDR_SHDN, 32'h8a);
    cmp("oe_n", 4'hf, oe_all);
    axi_wr(ADDR_SHDN, 32'h0);
    rd_chk(ADDR_SHDN, 32'h0);
    cmp("shoot", 0, shoot_cnt);
    tally_and_finish();
  end
endmodule
